// ---- hdl/mcl_misc_log.sv ----
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Function
// - write data or byte-enable parity error logs buffer entry id in bits 13:9
// - enhanced mode: second correctable read error logs second device id in bits 13:9
// - enhanced mode stores first device error bit mask in bits 29:14
// - enhanced mode stores second device error bit mask in bits 45:30
// - enhanced mode stores first device failing rank in bits 50:46
// - enhanced mode stores second device failing rank in bits 55:51
// - enhanced mode sets bit 62 on first correctable read capture
// - enhanced mode sets bit 63 on second correctable error capture
// - control register bit 1 enables the enhanced logging
// - controller 0 logs bank 9 only, controller 1 bank 13 only (bank index 0 of each)
module mcl_misc_log
	import mcl_pkg::*;
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         resetn,
	// avalon-mm slave
	input  wire logic [mcl_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	input  wire logic [3:0]                   avs_byteenable,
	output logic [31:0]                       avs_readdata,
	output logic                              avs_waitrequest,
	output logic [1:0]                        avs_response,
	// error event from the memory controller
	input  wire logic                         ev_ctl,
	input  wire logic [1:0]                   ev_bank,
	input  wire mcl_pkg::mcl_event_t          ev_kind,
	input  wire logic [4:0]                   ev_entry,
	input  wire logic [4:0]                   ev_device,
	input  wire logic [15:0]                  ev_mask,
	input  wire logic [4:0]                   ev_rank,
	input  wire logic [8:0]                   ev_addr_info,
	// bank selected for this log
	output logic [4:0]                        log_bank
);
	import mcl_pkg::*;

	// banks count upward from the controller's first bank; the sum never leaves five bits
	function automatic logic [4:0] bank_of(input logic ctl, input logic [1:0] idx);
		bank_of = (ctl ? CTL1_FIRST_BANK : CTL0_FIRST_BANK) + {3'h0, idx};
	endfunction : bank_of

	logic [1:0]  ctrl_q;
	logic [63:0] log_q;
	logic        ack_q;
	logic        clear;
	logic        hit;
	logic        ev_match;
	mcl_event_t  ev_gated;
	logic        req_first;
	logic        req_take;

	// one wait cycle per access: the first cycle registers read data and response,
	// the second lets the master take them, so no combinational path runs from log to readdata
	assign req_first       = (avs_read | avs_write) & ~ack_q;
	assign req_take        = (avs_read | avs_write) & ack_q;
	assign avs_waitrequest = req_first;
	assign hit   = (avs_address == MISC_LO_OFS) || (avs_address == MISC_HI_OFS) ||
	               (avs_address == CTRL_OFS) || (avs_address == CLEAR_OFS);
	assign clear = avs_write & ack_q & (avs_address == CLEAR_OFS) & avs_writedata[0];

	// only events aimed at the bank this log serves are captured
	assign ev_match = (bank_of(ev_ctl, ev_bank) == log_bank);
	assign ev_gated = ev_match ? ev_kind : MCL_EV_NONE;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req_first;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_q <= 2'h0;
		end else if (req_take && avs_write && avs_address == CTRL_OFS && avs_byteenable[0]) begin
			ctrl_q <= avs_writedata[1:0];
		end
	end

	// this log always serves bank index 0 of the selected controller
	assign log_bank = bank_of(ctrl_q[CTRL_CTL_SEL], 2'h0);

	// response is registered with the data so both stand at the taking edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_response <= 2'h0;
		end else if (req_first) begin
			avs_response <= hit ? 2'h0 : 2'h2;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_readdata <= 32'h0;
		end else if (req_first) begin
			case (avs_address)
				MISC_LO_OFS: avs_readdata <= log_q[31:0];
				MISC_HI_OFS: avs_readdata <= log_q[63:32];
				CTRL_OFS:    avs_readdata <= {30'h0, ctrl_q};
				default:     avs_readdata <= 32'h0;
			endcase
		end
	end

	mcl_capture u_capture (
		.clk          (clk),
		.resetn       (resetn),
		.enhanced_en  (ctrl_q[CTRL_ENH_BIT]),
		.clear        (clear),
		.ev_kind      (ev_gated),
		.ev_entry     (ev_entry),
		.ev_device    (ev_device),
		.ev_mask      (ev_mask),
		.ev_rank      (ev_rank),
		.ev_addr_info (ev_addr_info),
		.log_q        (log_q)
	);

	// bus timing and read path
	AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!resetn)
		($rose(avs_read) && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered after one wait cycle");

	AST_WAIT_ONE_WR: assert property (@(posedge clk) disable iff (!resetn)
		($rose(avs_write) && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("write not answered after one wait cycle");

	AST_NO_WAIT_IDLE: assert property (@(posedge clk) disable iff (!resetn)
		!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");

	AST_RD_LO: assert property (@(posedge clk) disable iff (!resetn)
		(req_first && avs_address == MISC_LO_OFS) |=> avs_readdata == $past(log_q[31:0]))
		else $error("low log word not returned");

	AST_RD_HI: assert property (@(posedge clk) disable iff (!resetn)
		(req_first && avs_address == MISC_HI_OFS) |=> avs_readdata == $past(log_q[63:32]))
		else $error("high log word not returned");

	AST_RD_CTRL: assert property (@(posedge clk) disable iff (!resetn)
		(req_first && avs_address == CTRL_OFS) |=> avs_readdata == {30'h0, $past(ctrl_q)})
		else $error("control word not returned");

	AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!req_first |=> $stable(avs_readdata))
		else $error("read data moved between accesses");

	AST_UNMAPPED: assert property (@(posedge clk) disable iff (!resetn)
		(req_first && !hit) |=> avs_response == 2'h2 && avs_readdata == 32'h0)
		else $error("unmapped access not refused");

	AST_MAPPED_OKAY: assert property (@(posedge clk) disable iff (!resetn)
		(req_first && hit) |=> avs_response == 2'h0)
		else $error("mapped access not okay");

	// control register
	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(req_take && avs_write && avs_address == CTRL_OFS && avs_byteenable[0])
		|=> ctrl_q == $past(avs_writedata[1:0]))
		else $error("control write lost");

	AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!(req_take && avs_write && avs_address == CTRL_OFS && avs_byteenable[0]) |=> $stable(ctrl_q))
		else $error("control changed without a write");

	AST_ENH_FROM_CTRL: assert property (@(posedge clk) disable iff (!resetn)
		(!ctrl_q[1] && !clear) |=> ($past(log_q[62]) == log_q[62]) || $past(clear))
		else $error("valid flag set while enhanced logging off");

	// log capture
	AST_PARITY_ENTRY: assert property (@(posedge clk) disable iff (!resetn)
		(ev_match && (ev_kind == MCL_EV_WR_DATA_PAR || ev_kind == MCL_EV_WR_BE_PAR))
		|=> log_q[13:9] == $past(ev_entry))
		else $error("buffer entry id not logged");

	AST_PARITY_ADDR: assert property (@(posedge clk) disable iff (!resetn)
		(ev_match && (ev_kind == MCL_EV_WR_DATA_PAR || ev_kind == MCL_EV_WR_BE_PAR))
		|=> log_q[8:0] == $past(ev_addr_info))
		else $error("address info not logged");

	AST_FIRST_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
		(ev_match && ctrl_q[1] && ev_kind == MCL_EV_CORR_READ && !log_q[62] && !clear)
		|=> log_q[62] && log_q[29:14] == $past(ev_mask) && log_q[50:46] == $past(ev_rank))
		else $error("first device not captured");

	AST_SECOND_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)
		(ev_match && ctrl_q[1] && ev_kind == MCL_EV_CORR_READ && log_q[62] && !log_q[63] && !clear)
		|=> log_q[63] && log_q[45:30] == $past(ev_mask) && log_q[55:51] == $past(ev_rank)
		&& log_q[13:9] == $past(ev_device))
		else $error("second device not captured");

	AST_THIRD_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
		(!clear && ev_gated == MCL_EV_CORR_READ && log_q[VALID1_BIT] && log_q[VALID2_BIT]) |=> $stable(log_q))
		else $error("third correctable read changed the log");

	AST_NO_EVENT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		(!clear && ev_gated == MCL_EV_NONE) |=> $stable(log_q))
		else $error("log changed without an event for this bank");

	AST_CLEAR_ZEROES: assert property (@(posedge clk) disable iff (!resetn)
		(clear && ev_gated == MCL_EV_NONE) |=> log_q == MISC_RESET)
		else $error("clear did not zero the log");

	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		log_q[61:56] == 6'h00)
		else $error("reserved bits nonzero");

	AST_BANK_RANGE: assert property (@(posedge clk) disable iff (!resetn)
		ctrl_q[0] ? (log_bank >= 5'h0d && log_bank <= 5'h10) : (log_bank >= 5'h09 && log_bank <= 5'h0c))
		else $error("bank out of controller range");

	COV_FIRST: cover property (@(posedge clk) disable iff (!resetn) $rose(log_q[62]));
	COV_SECOND: cover property (@(posedge clk) disable iff (!resetn) $rose(log_q[63]));
	COV_PARITY: cover property (@(posedge clk) disable iff (!resetn) ev_match && ev_kind == MCL_EV_WR_BE_PAR);
	COV_CLEAR: cover property (@(posedge clk) disable iff (!resetn) clear && log_q[62]);
	COV_UNMAPPED: cover property (@(posedge clk) disable iff (!resetn) req_first && !hit);
endmodule : mcl_misc_log

// ---- pkg/mcl_pkg.sv ----
package mcl_pkg;
	// register map (word byte addresses)
	localparam logic [3:0]  MISC_LO_OFS     = 4'h0;
	localparam logic [3:0]  MISC_HI_OFS     = 4'h4;
	localparam logic [3:0]  CTRL_OFS        = 4'h8;
	localparam logic [3:0]  CLEAR_OFS       = 4'hc;
	localparam int          ADDR_W          = 4;
	// misc log field layout
	localparam int          ADDR_INFO_LSB   = 0;
	localparam int          ADDR_INFO_W     = 9;
	localparam int          ENTRY_LSB       = 9;
	localparam int          ENTRY_W         = 5;
	localparam int          MASK1_LSB       = 14;
	localparam int          MASK2_LSB       = 30;
	localparam int          MASK_W          = 16;
	localparam int          RANK1_LSB       = 46;
	localparam int          RANK2_LSB       = 51;
	localparam int          RANK_W          = 5;
	localparam int          VALID1_BIT      = 62;
	localparam int          VALID2_BIT      = 63;
	// control register bits
	localparam int          CTRL_ENH_BIT    = 1;
	localparam int          CTRL_CTL_SEL    = 0;
	// controller to bank numbering
	localparam logic [4:0]  CTL0_FIRST_BANK = 5'h09;
	localparam logic [4:0]  CTL1_FIRST_BANK = 5'h0d;
	localparam logic [1:0]  BANKS_PER_CTL   = 2'h3;
	localparam logic [63:0] MISC_RESET      = 64'h0;
	// error event kinds
	typedef enum logic [1:0] {
		MCL_EV_NONE,
		MCL_EV_WR_DATA_PAR,
		MCL_EV_WR_BE_PAR,
		MCL_EV_CORR_READ
	} mcl_event_t;
endpackage : mcl_pkg

// ---- hdl/mcl_capture.sv ----
`timescale 1ns/1ps
module mcl_capture
	import mcl_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// control
	input  wire logic                   enhanced_en,
	input  wire logic                   clear,
	// error event from controller
	input  wire mcl_pkg::mcl_event_t    ev_kind,
	input  wire logic [4:0]             ev_entry,
	input  wire logic [4:0]             ev_device,
	input  wire logic [15:0]            ev_mask,
	input  wire logic [4:0]             ev_rank,
	input  wire logic [8:0]             ev_addr_info,
	// captured log
	output logic [63:0]                 log_q
);
	import mcl_pkg::*;

	logic [63:0] log_d;

	always_comb begin
		log_d = log_q;
		if (clear) begin
			log_d = MISC_RESET;
		end
		// a new event lands after the clear, so set beats clear
		case (ev_kind)
			MCL_EV_WR_DATA_PAR, MCL_EV_WR_BE_PAR: begin
				log_d[ENTRY_LSB +: ENTRY_W] = ev_entry;
				log_d[ADDR_INFO_LSB +: ADDR_INFO_W] = ev_addr_info;
			end
			MCL_EV_CORR_READ: begin
				if (enhanced_en) begin
					if (!log_d[VALID1_BIT]) begin
						log_d[MASK1_LSB +: MASK_W] = ev_mask;
						log_d[RANK1_LSB +: RANK_W] = ev_rank;
						log_d[VALID1_BIT] = 1'b1;
					end else if (!log_d[VALID2_BIT]) begin
						// second device only after first is held
						log_d[ENTRY_LSB +: ENTRY_W] = ev_device;
						log_d[MASK2_LSB +: MASK_W] = ev_mask;
						log_d[RANK2_LSB +: RANK_W] = ev_rank;
						log_d[VALID2_BIT] = 1'b1;
					end
				end
				// disabled: enhanced fields stay untouched
			end
			default: begin
			end
		endcase
		log_d[61:56] = 6'h00;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			log_q <= MISC_RESET;
		end else begin
			log_q <= log_d;
		end
	end

	AST_V2_NEEDS_V1: assert property (@(posedge clk) disable iff (!resetn)
		log_q[VALID2_BIT] |-> log_q[VALID1_BIT])
		else $error("second valid without first valid");
	AST_NO_ENH_WHEN_OFF: assert property (@(posedge clk) disable iff (!resetn)
		(!enhanced_en && !clear && ev_kind == MCL_EV_CORR_READ) |=> $stable(log_q[63:14]))
		else $error("enhanced fields written while disabled");
endmodule : mcl_capture

// ---- testbench/tb_mcl_misc_log.sv ----
`timescale 1ns/1ps
module tb_mcl_misc_log;
	import mcl_pkg::*;
	logic        clk, resetn, avs_read, avs_write, avs_waitrequest, ev_ctl;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0]  avs_response, ev_bank, rsp;
	mcl_event_t  ev_kind;
	logic [4:0]  ev_entry, ev_device, ev_rank, log_bank;
	logic [15:0] ev_mask;
	logic [8:0]  ev_addr_info;
	logic [63:0] lg, ex;
	int          miscompares, cmp_count;

	mcl_misc_log i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.ev_ctl(ev_ctl), .ev_bank(ev_bank), .ev_kind(ev_kind), .ev_entry(ev_entry), .ev_device(ev_device),
		.ev_mask(ev_mask), .ev_rank(ev_rank), .ev_addr_info(ev_addr_info), .log_bank(log_bank));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// request stands until the rising edge that samples waitrequest low; data taken at that edge, then dropped
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
		@(posedge clk);
		avs_read       <= ~wr;
		avs_write      <= wr;
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd  = avs_readdata;
		rsp = avs_response;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd64;
		bus(1'b0, MISC_LO_OFS, 32'h0);
		lg[31:0] = rd;
		bus(1'b0, MISC_HI_OFS, 32'h0);
		lg[63:32] = rd;
	endtask : rd64

	// one-cycle event pulse; address info only carried by parity events
	task automatic ev(mcl_event_t k, logic c, logic [1:0] b, logic [4:0] e, logic [4:0] dv, logic [15:0] m,
		logic [4:0] r);
		@(posedge clk);
		ev_kind      <= k;
		ev_ctl       <= c;
		ev_bank      <= b;
		ev_entry     <= e;
		ev_device    <= dv;
		ev_mask      <= m;
		ev_rank      <= r;
		ev_addr_info <= (k == MCL_EV_CORR_READ) ? 9'h0 : {e, 4'ha};
		@(posedge clk);
		ev_kind <= MCL_EV_NONE;
	endtask : ev

	task automatic t_parity;
		ev(MCL_EV_WR_DATA_PAR, 1'b0, 2'h0, 5'h1b, 5'h03, 16'hffff, 5'h1f);
		rd64();
		chk("wr data parity log", (64'h1b << ENTRY_LSB) | 64'h1ba, lg);
		ev(MCL_EV_WR_BE_PAR, 1'b0, 2'h0, 5'h04, 5'h03, 16'hffff, 5'h1f);
		rd64();
		ex = (64'h04 << ENTRY_LSB) | 64'h04a;
		chk("byte enable parity log", ex, lg);
		ev(MCL_EV_CORR_READ, 1'b0, 2'h0, 5'h00, 5'h11, 16'h5a5a, 5'h09);
		rd64();
		chk("corr read while disabled", ex, lg);
		$display("test parity done");
	endtask : t_parity

	task automatic t_enhanced;
		bus(1'b1, CTRL_OFS, 32'h2);
		bus(1'b1, CLEAR_OFS, 32'h1);
		ev(MCL_EV_CORR_READ, 1'b0, 2'h0, 5'h00, 5'h07, 16'hbeef, 5'h0a);
		rd64();
		ex = (64'hbeef << MASK1_LSB) | (64'h0a << RANK1_LSB) | (64'h1 << VALID1_BIT);
		chk("first device log", ex, lg);
		ev(MCL_EV_CORR_READ, 1'b0, 2'h0, 5'h00, 5'h13, 16'h1234, 5'h15);
		rd64();
		ex |= (64'h13 << ENTRY_LSB) | (64'h1234 << MASK2_LSB) | (64'h15 << RANK2_LSB) | (64'h1 << VALID2_BIT);
		chk("second device log", ex, lg);
		chk("second valid only with first", 64'h3, 64'(lg[63:62]));
		ev(MCL_EV_CORR_READ, 1'b0, 2'h0, 5'h00, 5'h1e, 16'hffff, 5'h1f);
		rd64();
		chk("third corr read kept out", ex, lg);
		bus(1'b1, CTRL_OFS, 32'h0, 4'he);
		bus(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl write without lane 0", 64'h2, 64'(rd));
		bus(1'b1, MISC_LO_OFS, 32'hffffffff);
		rd64();
		chk("misc log not writable", ex, lg);
		$display("test enhanced done");
	endtask : t_enhanced

	task automatic t_bank;
		bus(1'b1, CTRL_OFS, 32'h3);
		@(posedge clk);
		chk("bank second controller", 64'd13, 64'(log_bank));
		bus(1'b1, CLEAR_OFS, 32'h1);
		ev(MCL_EV_CORR_READ, 1'b0, 2'h0, 5'h00, 5'h01, 16'h0f0f, 5'h02);
		ev(MCL_EV_CORR_READ, 1'b1, 2'h1, 5'h00, 5'h01, 16'h0f0f, 5'h02);
		rd64();
		chk("foreign bank ignored", 64'h0, lg);
		ev(MCL_EV_CORR_READ, 1'b1, 2'h0, 5'h00, 5'h01, 16'h0f0f, 5'h02);
		rd64();
		ex = (64'h0f0f << MASK1_LSB) | (64'h02 << RANK1_LSB) | (64'h1 << VALID1_BIT);
		chk("own bank logged", ex, lg);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped response", 64'h2, 64'(rsp));
		chk("unmapped read data", 64'h0, 64'(rd));
		$display("test bank done");
	endtask : t_bank

	initial begin
		#40000;
		miscompares++;
		final_report();
	end

	initial begin
		{resetn, avs_read, avs_write, ev_ctl, ev_bank, ev_entry, ev_device, ev_mask, ev_rank} = '0;
		{avs_address, avs_writedata, ev_addr_info} = '0;
		avs_byteenable = 4'hf;
		ev_kind = MCL_EV_NONE;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd64();
		chk("log after reset", 64'h0, lg);
		chk("okay response", 64'h0, 64'(rsp));
		chk("bank after reset", 64'd9, 64'(log_bank));
		$display("test reset done");
		t_parity();
		t_enhanced();
		t_bank();
		final_report();
	end
endmodule : tb_mcl_misc_log
